/* File: aprl_latch.sv */
// Purpose: axis position registration latch with APB register access
// Assumes: all pins synchronous to clock, encoder is 4x quadrature
// Notes:   two latches; drive-side variants model the remote drive timing
`timescale 1ns/1ps
`include "aprl_cfg.svh"

module aprl_latch
    import aprl_pkg::*;
#(
    parameter int POS_W       = 32,                   // position width
    parameter int CNT_W       = 20,                   // delay counter width
    parameter int REFRESH_CYC = `APRL_REFRESH_CYC,    // drive sample period
    parameter int ARM_CYC     = `APRL_ARM_CYC,        // drive arming delay
    parameter int DELIVER_CYC = `APRL_DELIVER_CYC     // drive delivery delay
) (
    input  wire logic        clock,        // 250 MHz clock
    input  wire logic        rst_b,        // async reset, active low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb enable
    input  wire logic        pwrite,       // apb direction
    input  wire logic [7:0]  paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error, unmapped address
    input  wire logic        enc_a,        // encoder phase a
    input  wire logic        enc_b,        // encoder phase b
    input  wire logic        enc_z,        // encoder zero mark
    input  wire logic [1:0]  cap_in,       // local capture inputs
    input  wire logic [2:0]  drv_in,       // drive-side capture inputs
    output logic      [1:0]  latch_valid   // capture-valid flags
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    logic [POS_W-1:0]   pos_count;                // live encoder count
    logic [POS_W-1:0]   next_count;               // count after this edge
    logic               prev_a;                   // phase a last cycle
    logic               prev_b;                   // phase b last cycle
    aprl_phys_t         phys_now;                 // capture pins now
    aprl_phys_t         phys_prev;                // capture pins last cycle
    aprl_phys_t         rise;                     // rising edges
    aprl_phys_t         fall;                     // falling edges
    logic [CNT_W-1:0]   refresh_cnt;              // cycles since drive sample
    logic               refresh_tick;             // drive sample instant
    logic [POS_W-1:0]   drive_sample;             // last drive-side sample
    aprl_variant_t      axis_type_param;          // path and drive variant
    logic               drive_enable_flag;        // drive power stage on
    logic [15:0]        input_latch_map_param;    // digit per logical source
    logic [7:0]         input_function_select_five;   // selector of input 5
    logic [7:0]         input_function_select_six;    // selector of input 6
    logic [7:0]         input_function_select_seven;  // selector of input 7
    logic               acc_done;                 // apb access completes
    logic               wr_done;                  // apb write completes
    logic [31:0]        next_rdata;               // read mux
    logic               next_err;                 // unmapped address
    logic [1:0]         arm_req;                  // accepted arm writes
    aprl_arm_t          capture_arm_command [2];  // arm word per latch
    aprl_state_t        state [2];                // latch sequence state
    logic [CNT_W-1:0]   cnt [2];                  // delay counter per latch
    logic [POS_W-1:0]   base [2];                 // sample before capture
    logic [CNT_W-1:0]   elapsed [2];              // capture offset in period
    logic [POS_W-1:0]   cap_pos [2];              // captured position
    logic [1:0]         hit;                      // selected edge seen
    logic [1:0]         set_evt;                  // valid flag being set
    logic [1:0]         busy;                     // latch in sequence

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // interpolate between two samples; drive only sees 62.5 us snapshots
    function automatic logic [POS_W-1:0] interp(input logic [POS_W-1:0] b,
                                                input logic [POS_W-1:0] c,
                                                input logic [CNT_W-1:0] el);
        logic signed [POS_W:0]         d;
        logic signed [POS_W+CNT_W+1:0] p;
        d = $signed({c[POS_W-1], c}) - $signed({b[POS_W-1], b});
        p = (POS_W+CNT_W+2)'(d * $signed({1'b0, el}));
        p = p / $signed((POS_W+CNT_W+2)'(REFRESH_CYC));
        return b + p[POS_W-1:0];
    endfunction : interp

    // drive hex digit to trigger: 4..6 rise, d..f fall, 8 on, rest never
    function automatic logic code_hit(input logic [3:0] code,
                                      input logic [2:0] r,
                                      input logic [2:0] f);
        case (code)
            `APRL_CODE_RISE1: return r[0];
            `APRL_CODE_RISE2: return r[1];
            `APRL_CODE_RISE3: return r[2];
            `APRL_CODE_ON:    return 1'b1;
            `APRL_CODE_FALL1: return f[0];
            `APRL_CODE_FALL2: return f[1];
            `APRL_CODE_FALL3: return f[2];
            default:          return 1'b0;  // unused codes and forced off
        endcase
    endfunction : code_hit

    // selector value that assigns an input to a logical source
    function automatic logic [7:0] sel_target(input logic [1:0] src);
        case (src)
            2'd1:    return `APRL_SEL_SRC1;
            2'd2:    return `APRL_SEL_SRC2;
            2'd3:    return `APRL_SEL_SRC3;
            default: return 8'hFF;  // zero mark never matches a selector
        endcase
    endfunction : sel_target

    // register field to variant; unknown codes fall back to local path
    function automatic aprl_variant_t to_variant(input logic [2:0] v);
        case (v)
            3'd1:    return av_mapped;
            3'd2:    return av_single;
            3'd3:    return av_fixed;
            3'd4:    return av_dual;
            default: return av_local;
        endcase
    endfunction : to_variant

    ////////////////////////////////////////////////////////////////////////////
    // encoder count, read continuously on the same board as the latches

    // one step when exactly one phase toggles
    always_comb begin
        next_count = pos_count;
        if ((enc_a ^ prev_a) != (enc_b ^ prev_b)) begin
            if (enc_a ^ prev_b) begin  // a leads b
                next_count = pos_count + 1'b1;
            end else begin
                next_count = pos_count - 1'b1;
            end
        end
    end

    // count register feeds the latches directly
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pos_count <= '0;
            prev_a    <= 1'b0;
            prev_b    <= 1'b0;
        end else begin
            pos_count <= next_count;
            prev_a    <= enc_a;
            prev_b    <= enc_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture edges

    assign phys_now = '{drv: drv_in, zmark: enc_z, cap: cap_in};
    assign rise     = phys_now & ~phys_prev;
    assign fall     = ~phys_now & phys_prev;

    // previous pin levels for edge detection
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phys_prev <= '0;
        end else begin
            phys_prev <= phys_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // drive-side sample refresh

    assign refresh_tick = (refresh_cnt == CNT_W'(REFRESH_CYC - 1));

    // drive only learns the position once per refresh period
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            refresh_cnt  <= '0;
            drive_sample <= '0;
        end else if (refresh_tick) begin
            refresh_cnt  <= '0;
            drive_sample <= pos_count;
        end else begin
            refresh_cnt  <= refresh_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, registered answer

    assign acc_done = psel & penable & pready;
    assign wr_done  = acc_done & pwrite;

    // read mux and address decode
    always_comb begin
        next_rdata = '0;
        next_err   = 1'b0;
        case (paddr)
            `APRL_OFF_CONFIG: next_rdata = 32'({drive_enable_flag, axis_type_param});
            `APRL_OFF_MAP:    next_rdata = 32'(input_latch_map_param);
            `APRL_OFF_SELECT: next_rdata = 32'({input_function_select_seven,
                                                input_function_select_six,
                                                input_function_select_five});
            `APRL_OFF_ARM_A:  next_rdata = 32'(capture_arm_command[0]);
            `APRL_OFF_ARM_B:  next_rdata = 32'(capture_arm_command[1]);
            `APRL_OFF_STATUS: next_rdata = 32'({busy, latch_valid});
            `APRL_OFF_POS_A:  next_rdata = 32'(cap_pos[0]);
            `APRL_OFF_POS_B:  next_rdata = 32'(cap_pos[1]);
            `APRL_OFF_LIVE:   next_rdata = 32'(pos_count);
            default:          next_err   = 1'b1;
        endcase
    end

    // ready rises one cycle into the access phase, data with it
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            if (psel & penable & ~pready & ~pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            axis_type_param             <= av_local;
            drive_enable_flag           <= 1'b0;
            input_latch_map_param       <= `APRL_RST_MAP;
            input_function_select_five  <= `APRL_RST_SELECT;
            input_function_select_six   <= `APRL_RST_SELECT;
            input_function_select_seven <= `APRL_RST_SELECT;
        end else if (wr_done) begin
            if (paddr == `APRL_OFF_CONFIG) begin
                axis_type_param   <= to_variant(pwdata[2:0]);
                drive_enable_flag <= pwdata[`APRL_CFG_DRVEN_BIT];
            end
            if (paddr == `APRL_OFF_MAP) begin
                input_latch_map_param <= pwdata[15:0];
            end
            if (paddr == `APRL_OFF_SELECT) begin
                input_function_select_five  <= pwdata[7:0];
                input_function_select_six   <= pwdata[15:8];
                input_function_select_seven <= pwdata[23:16];
            end
        end
    end

    // second latch exists only on the local path and the dual-latch drive
    always_comb begin
        arm_req[0] = wr_done & (paddr == `APRL_OFF_ARM_A);
        arm_req[1] = wr_done & (paddr == `APRL_OFF_ARM_B) &
                     ((axis_type_param == av_local) | (axis_type_param == av_dual));
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger selection per latch

    // decode the arm word against the active variant
    always_comb begin
        hit = '0;
        for (int ch = 0; ch < 2; ch++) begin
            aprl_phys_t e;
            aprl_arm_t  a;
            a = capture_arm_command[ch];
            e = a.falling ? fall : rise;
            if (a.src == 2'd0) begin
                hit[ch] = e.zmark;
            end else begin
                unique case (axis_type_param)
                    av_local:  hit[ch] = (a.src == 2'd1) ? e.cap[0] :
                                         (a.src == 2'd2) ? e.cap[1] : 1'b0;
                    av_mapped: hit[ch] = code_hit(input_latch_map_param[{a.src, 2'b00} +: 4],
                                                  rise.drv, fall.drv);
                    av_single: hit[ch] = (a.src == 2'd1) & rise.drv[0];
                    av_fixed:  hit[ch] = rise.drv[a.src - 2'd1];
                    av_dual: begin
                        hit[ch] = ((input_function_select_five  == sel_target(a.src)) & e.drv[0])
                                | ((input_function_select_six   == sel_target(a.src)) & e.drv[1])
                                | ((input_function_select_seven == sel_target(a.src)) & e.drv[2]);
                    end
                endcase
            end
            // power stage off blocks these two drives; latch keeps waiting, those edges are lost
            if (((axis_type_param == av_fixed) | (axis_type_param == av_dual)) &
                !drive_enable_flag) begin
                hit[ch] = 1'b0;
            end
        end
    end

    // events that set the valid flag this cycle
    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            set_evt[ch] = ((state[ch] == st_edge_wait) & hit[ch] & (axis_type_param == av_local))
                        | ((state[ch] == st_deliver) & (cnt[ch] == '0));
            busy[ch]    = (state[ch] != st_idle) & (state[ch] != st_held);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // latch sequencers; a capture landing with an arm write wins over it

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            latch_valid <= '0;
            for (int ch = 0; ch < 2; ch++) begin
                state[ch]               <= st_idle;
                cnt[ch]                 <= '0;
                base[ch]                <= '0;
                elapsed[ch]             <= '0;
                cap_pos[ch]             <= '0;
                capture_arm_command[ch] <= '0;
            end
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                if (arm_req[ch] && !set_evt[ch]) begin
                    capture_arm_command[ch] <= aprl_arm_t'(pwdata[2:0]);
                    latch_valid[ch]         <= 1'b0;
                    cnt[ch]                 <= CNT_W'(ARM_CYC - 1);
                    // local latch is live at once, drive needs its arming time
                    state[ch] <= (axis_type_param == av_local) ? st_edge_wait
                                                               : st_arm_wait;
                end else begin
                    unique case (state[ch])
                        st_idle: begin
                        end
                        st_arm_wait: begin
                            if (cnt[ch] == '0) begin
                                state[ch] <= st_edge_wait;
                            end else begin
                                cnt[ch] <= cnt[ch] - 1'b1;
                            end
                        end
                        st_edge_wait: begin
                            if (hit[ch] && axis_type_param == av_local) begin
                                // count taken directly, readable next cycle
                                cap_pos[ch]     <= pos_count;
                                latch_valid[ch] <= 1'b1;
                                state[ch]       <= st_held;
                            end else if (hit[ch]) begin
                                cnt[ch]   <= CNT_W'(`APRL_CAPDLY_CYC - 1);
                                state[ch] <= st_cap_delay;
                            end
                        end
                        st_cap_delay: begin  // drive latch reacts late
                            if (cnt[ch] != '0) begin
                                cnt[ch] <= cnt[ch] - 1'b1;
                            end else if (refresh_tick) begin
                                // next sample is the live count itself
                                cap_pos[ch] <= interp(drive_sample, pos_count,
                                                      refresh_cnt);
                                cnt[ch]     <= CNT_W'(DELIVER_CYC - 1);
                                state[ch]   <= st_deliver;
                            end else begin
                                base[ch]    <= drive_sample;
                                elapsed[ch] <= refresh_cnt;
                                state[ch]   <= st_refresh_wait;
                            end
                        end
                        st_refresh_wait: begin
                            if (refresh_tick) begin
                                cap_pos[ch] <= interp(base[ch], pos_count,
                                                      elapsed[ch]);
                                cnt[ch]     <= CNT_W'(DELIVER_CYC - 1);
                                state[ch]   <= st_deliver;
                            end
                        end
                        st_deliver: begin
                            if (cnt[ch] == '0) begin
                                latch_valid[ch] <= 1'b1;
                                state[ch]       <= st_held;
                            end else begin
                                cnt[ch] <= cnt[ch] - 1'b1;
                            end
                        end
                        st_held: begin  // edges ignored until rearmed
                        end
                    endcase
                end
            end
        end
    end

endmodule : aprl_latch

/* File: aprl_cfg.svh */
// Purpose: offsets, field positions, reset values and timing counts of the registration latch
// Assumes: 250 MHz clock, one aligned 32-bit word per register on APB
// Notes:   included by the latch module only
`ifndef APRL_CFG_SVH
`define APRL_CFG_SVH

// register byte offsets
`define APRL_OFF_CONFIG   8'h00
`define APRL_OFF_MAP      8'h04
`define APRL_OFF_SELECT   8'h08
`define APRL_OFF_ARM_A    8'h0C
`define APRL_OFF_ARM_B    8'h10
`define APRL_OFF_STATUS   8'h14
`define APRL_OFF_POS_A    8'h18
`define APRL_OFF_POS_B    8'h1C
`define APRL_OFF_LIVE     8'h20

// field positions
`define APRL_CFG_DRVEN_BIT 3
`define APRL_STAT_BUSY_LSB 2

// reset values
`define APRL_RST_MAP      16'h0000
`define APRL_RST_SELECT   8'h00

// latch source digit codes
`define APRL_CODE_RISE1   4'h4
`define APRL_CODE_RISE2   4'h5
`define APRL_CODE_RISE3   4'h6
`define APRL_CODE_OFF     4'h7
`define APRL_CODE_ON      4'h8
`define APRL_CODE_FALL1   4'hD
`define APRL_CODE_FALL2   4'hE
`define APRL_CODE_FALL3   4'hF

// input function selector values
`define APRL_SEL_DISABLED 8'h00
`define APRL_SEL_SRC1     8'h20
`define APRL_SEL_SRC2     8'h21
`define APRL_SEL_SRC3     8'h28

// times in ns and derived cycle counts
`define APRL_CLK_NS        4
`define APRL_T_REFRESH_NS  62500
`define APRL_T_CAPDLY_NS   3000
`define APRL_T_ARM_NS      625000
`define APRL_T_DELIVER_NS  3500000
`define APRL_T_LOCAL_NS    500
`define APRL_REFRESH_CYC   (`APRL_T_REFRESH_NS / `APRL_CLK_NS)
`define APRL_CAPDLY_CYC    (`APRL_T_CAPDLY_NS / `APRL_CLK_NS)
`define APRL_ARM_CYC       ((`APRL_T_ARM_NS + `APRL_CLK_NS - 1) / `APRL_CLK_NS)
`define APRL_DELIVER_CYC   (`APRL_T_DELIVER_NS / `APRL_CLK_NS)
`define APRL_LOCAL_MAX_CYC (`APRL_T_LOCAL_NS / `APRL_CLK_NS)

`endif

/* File: aprl_pkg.sv */
// Purpose: types shared by the registration latch
// Assumes: nothing beyond SystemVerilog packed types
// Notes:   arm word layout matches the arm register bits
package aprl_pkg;
    // which capture path and drive variant is active
    typedef enum logic [2:0] {av_local, av_mapped, av_single, av_fixed, av_dual} aprl_variant_t;
    // per-latch sequencing
    typedef enum logic [2:0] {
        st_idle, st_arm_wait, st_edge_wait, st_cap_delay, st_refresh_wait, st_deliver, st_held
    } aprl_state_t;
    // arm word: edge choice over source choice
    typedef struct packed {
        logic       falling;  // capture on falling edge
        logic [1:0] src;      // 0 zero mark, 1..3 capture source
    } aprl_arm_t;
    // every physical capture signal in one bundle
    typedef struct packed {
        logic [2:0] drv;      // drive-side inputs
        logic       zmark;    // encoder zero mark
        logic [1:0] cap;      // local capture inputs
    } aprl_phys_t;
endpackage : aprl_pkg

/* File: aprl_latch_sva.sv */
// Purpose: port checks; Assumes: local variant timing; Notes: bind at foot
`timescale 1ns/1ps
module aprl_chk (
    input wire logic        clock,       // clock
    input wire logic        rst_b,       // reset
    input wire logic        psel,        // select
    input wire logic        penable,     // enable
    input wire logic        pwrite,      // direction
    input wire logic        pready,      // ready
    input wire logic        pslverr,     // error
    input wire logic [7:0]  paddr,       // address
    input wire logic [31:0] pwdata,      // write data
    input wire logic        enc_z,       // zero mark
    input wire logic [1:0]  cap_in,      // capture pins
    input wire logic [1:0]  latch_valid  // valid flags
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire  wr = pready && pwrite && !pslverr;  // write lands
    wire  arm_a = wr && paddr == 8'h0C;       // arm of latch a
    wire  arm_b = wr && paddr == 8'h10;       // arm of latch b
    logic loc;                                // local variant, the fast path
    ////////////////////////////////////////////////////////////////
    // variant tracking; drive paths are too slow to bound here
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) loc <= 1'h1;
        else if (wr && paddr == 8'h00) loc <= pwdata[2:0] == 3'h0 || pwdata[2:0] > 3'h4;
    end
    a_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready stuck");
    a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
        else $error("ready without access");
    a_arm_clears: assert property (arm_a && latch_valid[0] && $stable(cap_in)
        && $stable(enc_z) |=> !latch_valid[0]) else $error("arm kept valid");
    a_hold_a: assert property (latch_valid[0] && !arm_a |=> latch_valid[0]) else $error("a lost");
    a_hold_b: assert property (latch_valid[1] && !arm_b |=> latch_valid[1]) else $error("b lost");
    a_fast_a: assert property (loc && $rose(latch_valid[0]) |-> $past(cap_in) != $past(cap_in, 2)
        || $past(enc_z) != $past(enc_z, 2)) else $error("a without edge");
    a_fast_b: assert property (loc && $rose(latch_valid[1]) |-> $past(cap_in) != $past(cap_in, 2)
        || $past(enc_z) != $past(enc_z, 2)) else $error("b without edge");
    c_cap_a: cover property ($rose(latch_valid[0]));
    c_cap_b: cover property ($rose(latch_valid[1]));
    c_err: cover property (pready && pslverr);
endmodule : aprl_chk
bind aprl_latch aprl_chk u_chk (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .enc_z(enc_z), .cap_in(cap_in), .latch_valid(latch_valid));

/* File: aprl_enc_model.sv */
// Purpose: encoder source; Assumes: one count a step; Notes: a leads b counting up
`timescale 1ns/1ps
module aprl_enc_model (
    input  wire logic clock,  // clock
    input  wire logic step,   // one count up
    input  wire logic zmark,  // zero mark request
    output logic      enc_a,  // phase a
    output logic      enc_b,  // phase b
    output logic      enc_z   // zero mark pin
);
    logic [1:0] ph = 2'h0;                    // quadrature phase
    always @(posedge clock) if (step) ph <= ph + 2'h1;
    assign enc_a = ph == 2'h1 || ph == 2'h2;  // local count source
    assign enc_b = ph[1];                     // b trails a
    assign enc_z = zmark;                     // zero mark source
endmodule : aprl_enc_model

/* File: tb.sv */
// Purpose: latch bench; Assumes: local variant, then fixed-map drive; Notes: drive pins from index 3
`timescale 1ns/1ps
module tb;
    logic        clock = 1'h0, rst_b = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er;
    logic        step = 1'h0, zm = 1'h0;     // encoder requests
    logic [2:0]  drv = 3'h0;                 // drive-side pins
    logic [7:0]  paddr = 8'h00;              // bus address
    logic [31:0] pwdata = 32'h0000_0000, rd; // bus data
    logic [1:0]  cap_in = 2'h2;              // pin b starts high for a fall
    wire  [31:0] prdata;                     // read data
    wire         pready, pslverr, enc_a, enc_b, enc_z;
    wire  [1:0]  latch_valid;                // valid flags
    int          errors = 0, checks_done = 0;
    initial forever #2 clock = ~clock;
    aprl_latch #(.REFRESH_CYC(16), .ARM_CYC(4), .DELIVER_CYC(8)) dut (.clock(clock), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
        .enc_z(enc_z), .cap_in(cap_in), .drv_in(drv), .latch_valid(latch_valid));
    aprl_enc_model enc (.clock(clock), .step(step), .zmark(zm), .enc_a(enc_a), .enc_b(enc_b),
        .enc_z(enc_z));
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    // request held to the edge that samples ready high, data taken and released there
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clock) penable <= 1'h1;
        do @(posedge clock); while (pready !== 1'h1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask : apb
    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc
    // pin 2 is the zero mark, 3 up the drive pins; flags looked at two falling edges after the change
    task pin(input int i, input logic v, input logic [1:0] e);
        @(posedge clock) if (i == 2) zm <= v; else if (i > 2) drv[i-3] <= v; else cap_in[i] <= v;
        repeat (2) @(negedge clock);
        chk({30'h0, latch_valid}, {30'h0, e});
    endtask : pin
    task mv(input int n);
        repeat (n) begin
            @(posedge clock) step <= 1'h1;
            @(posedge clock) step <= 1'h0;
        end
        repeat (4) @(posedge clock);
    endtask : mv
    task give_verdict;
        $display("errors %0d, checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'h1;
        rdc(8'h14, 32'h0000_0000);
        apb(1'h0, 8'h40, 32'h0000_0000);   // unmapped place
        chk({31'h0, er}, 32'h0000_0001);
        mv(5);
        rdc(8'h20, 32'h0000_0005);
        apb(1'h1, 8'h0C, 32'h0000_0001);   // rising pin a
        apb(1'h1, 8'h10, 32'h0000_0006);   // falling pin b
        pin(1, 1'h0, 2'h2);
        pin(0, 1'h1, 2'h3);
        mv(3);
        pin(0, 1'h0, 2'h3);
        pin(0, 1'h1, 2'h3);
        rdc(8'h18, 32'h0000_0005);
        rdc(8'h1C, 32'h0000_0005);
        apb(1'h1, 8'h0C, 32'h0000_0000);   // zero mark source
        @(negedge clock) chk({30'h0, latch_valid}, 32'h0000_0002);
        pin(2, 1'h1, 2'h3);
        rdc(8'h18, 32'h0000_0008);
        mv(2);                             // live count now 10
        apb(1'h1, 8'h00, 32'h0000_0003);   // fixed map, drive off
        apb(1'h1, 8'h0C, 32'h0000_0001);   // arm source one
        repeat (8) @(posedge clock);       // arming time passes
        pin(3, 1'h1, 2'h2);                // edge while drive off
        pin(3, 1'h0, 2'h2);
        repeat (800) @(posedge clock);     // longer than a drive capture
        rdc(8'h14, 32'h0000_0006);         // still waiting, no capture
        apb(1'h1, 8'h00, 32'h0000_000B);   // drive enabled
        pin(3, 1'h1, 2'h2);                // capture starts, result comes late
        repeat (800) @(posedge clock);     // delay, refresh and delivery
        rdc(8'h14, 32'h0000_0003);
        rdc(8'h18, 32'h0000_000A);
        give_verdict;
    end
    initial begin
        repeat (4000) @(posedge clock);
        errors++;
        give_verdict;
    end
endmodule : tb
